//--- rtl/mode_auth_device.sv
// frontend end: mode switch and card authentication command handling
// Notes on behaviour
// - mode switch code 0B, selector then parameters
// - switch only from normal, never back
// - finished low power mode returns to normal
// - host leaves low power modes early by reset
// - selector 0 standby, 1 detection, 2 listen
// - wake control bit 1 wakes on field
// - wake control bit 0 wakes on counter
// - wake counter in ms, 1 to 2690
// - counter sent in standby and detection frames, ignored if unused
// - host sends nothing during low power modes
// - mode termination raises the interrupt request
// - detection interval is the wake counter
// - listen sub-modes 0, 1, 2 field handling
// - technology mask bits 3..0, upper reserved
// - authentication code 0C, key, type, block, uid
// - key type 60 or 61 only
// - any block address is accepted
// - status 0 ok, 1 denied, 2 timeout
// - second general timer busy during authentication
// - host activates card before authentication
// - bad parameters raise exception, no execution
`timescale 1ns/1ps
module mode_auth_device #(
    parameter int CYC_PER_MS = mode_auth_pkg::MS_CYCLES,
    parameter int AUTH_TMO_CYC = mode_auth_pkg::AUTH_TIMEOUT_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    cmd_link_if.dev link,
    input wire logic rf_field_i,
    input wire logic card_present_i,
    input wire logic listen_done_i,
    input wire logic auth_result_valid_i,
    input wire logic auth_denied_i,
    output logic standby_o,
    output logic low_power_card_detection_o,
    output logic scan_probe_o,
    output logic listen_active_o,
    output logic [3:0] listen_tech_o,
    output logic auth_req_o,
    output logic [47:0] auth_key_o,
    output logic auth_key_b_o,
    output logic [7:0] auth_block_o,
    output logic [31:0] auth_uid_o,
    output logic second_general_timer_busy_o,
    output logic exception_o
);
    import mode_auth_pkg::*;

    typedef enum logic [2:0] {
        ST_NORMAL, ST_STANDBY, ST_SCAN, ST_LISTEN, ST_LISTEN_SB, ST_AUTH
    } dev_state_t;

    // ********
    // link clock domain: frame receiver
    // ********
    logic first_ff;
    logic [6:0] bit_cnt_ff;
    logic [FRAME_BITS-1:0] shift_ff;
    logic [7:0] resp_ff;
    logic [2:0] miso_idx;

    // marks the first edge of a frame; set while select is idle
    always_ff @(posedge link.sck or posedge link.nss_n) begin
        if (link.nss_n) begin
            first_ff <= 1'b1;
        end else begin
            first_ff <= 1'b0;
        end
    end

    // bit count survives the frame end so the system side can read it
    always_ff @(posedge link.sck) begin
        if (first_ff) begin
            bit_cnt_ff <= 7'h01;
        end else if (bit_cnt_ff != BIT_CNT_MAX) begin
            bit_cnt_ff <= bit_cnt_ff + 7'h01;
        end
        shift_ff <= {shift_ff[FRAME_BITS-2:0], link.mosi};
    end

    // status byte shifted out msb first
    assign miso_idx = first_ff ? 3'h7 : ~bit_cnt_ff[2:0];
    assign link.miso = resp_ff[miso_idx];

    // ********
    // system domain: synchronisers
    // ********
    logic nss_s1_ff, nss_s2_ff, nss_s3_ff;
    logic rst_s1_ff, rst_s2_ff;
    logic rst;
    logic frame_done;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            nss_s1_ff <= 1'b1;
            nss_s2_ff <= 1'b1;
            nss_s3_ff <= 1'b1;
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            nss_s1_ff <= link.nss_n;
            nss_s2_ff <= nss_s1_ff;
            nss_s3_ff <= nss_s2_ff;
            rst_s1_ff <= link.dev_rst;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    assign rst = rst_i | rst_s2_ff;
    assign frame_done = nss_s2_ff & ~nss_s3_ff;

    // ********
    // frame decode (receiver is idle and stable here)
    // ********
    logic [3:0] n_bytes;
    logic whole;

    function automatic logic [7:0] fbyte(input logic [FRAME_BITS-1:0] sh,
        input logic [3:0] n, input int k);
        logic [FRAME_BITS-1:0] t;
        t = sh >> (8 * (int'(n) - 1 - k));
        return t[7:0];
    endfunction

    assign n_bytes = bit_cnt_ff[6:3];
    assign whole = (bit_cnt_ff[2:0] == 3'h0);

    wire [7:0] cmd = fbyte(shift_ff, n_bytes, 0);
    wire [7:0] sel = fbyte(shift_ff, n_bytes, 1);
    wire [7:0] p2 = fbyte(shift_ff, n_bytes, 2);
    wire [7:0] p3 = fbyte(shift_ff, n_bytes, 3);
    wire [7:0] p4 = fbyte(shift_ff, n_bytes, 4);
    wire [15:0] sb_wake = {p4, p3};
    wire [15:0] lp_wake = {p3, p2};
    wire sb_range = (sb_wake >= WAKE_MIN) && (sb_wake <= WAKE_MAX);
    wire lp_range = (lp_wake >= WAKE_MIN) && (lp_wake <= WAKE_MAX);
    wire is_switch = whole && (cmd == CMD_SWITCH_MODE);
    wire is_auth = whole && (cmd == CMD_CARD_AUTH);
    // counter range only checked when the counter is a wake source
    wire sb_ok = (sel == MODE_STANDBY) && (n_bytes == LEN_STANDBY)
        && ((p2 & WAKE_RSVD_MASK) == 8'h00)
        && (!p2[WAKE_CNT_BIT] || sb_range);
    wire lp_ok = (sel == MODE_SCAN) && (n_bytes == LEN_SCAN) && lp_range;
    wire li_ok = (sel == MODE_LISTEN) && (n_bytes == LEN_LISTEN)
        && ((p2 & TECH_RSVD_MASK) == 8'h00) && (p3 <= LISTEN_SUB_MAX);
    wire [7:0] key_type = fbyte(shift_ff, n_bytes, 7);
    wire au_ok = (n_bytes == LEN_AUTH)
        && ((key_type == KEY_TYPE_A) || (key_type == KEY_TYPE_B));
    wire sw_ok = sb_ok || lp_ok || li_ok;
    wire bad_cmd = (is_switch && !sw_ok) || (is_auth && !au_ok);

    // ********
    // system domain: mode controller
    // ********
    dev_state_t state_ff;
    logic [31:0] div_ff;
    logic [15:0] wake_ff, interval_ff;
    logic [31:0] auth_cnt_ff;
    logic [1:0] wake_en_ff;
    logic [7:0] sub_ff;
    logic irq_ff;
    logic ms_tick, expire, in_normal, leave;

    assign in_normal = (state_ff == ST_NORMAL);
    assign ms_tick = (div_ff == 32'(CYC_PER_MS - 1));
    assign expire = ms_tick && (wake_ff == WAKE_MIN);

    // conditions that end a low power mode or the authentication
    always_comb begin
        case (state_ff)
            ST_STANDBY: leave = (wake_en_ff[WAKE_RF_BIT] && rf_field_i)
                || (wake_en_ff[WAKE_CNT_BIT] && expire);
            ST_SCAN: leave = expire && card_present_i;
            ST_LISTEN: leave = listen_done_i
                || (!rf_field_i && (sub_ff == LISTEN_SUB_ONCE));
            ST_LISTEN_SB: leave = listen_done_i;
            ST_AUTH: leave = auth_result_valid_i
                || (auth_cnt_ff == 32'(AUTH_TMO_CYC - 1));
            default: leave = 1'b0;
        endcase
    end

    // state, timers and status
    always_ff @(posedge sys_clk_i) begin
        if (rst) begin
            state_ff <= ST_NORMAL;
            div_ff <= '0;
            wake_ff <= WAKE_MIN;
            interval_ff <= WAKE_MIN;
            auth_cnt_ff <= '0;
            wake_en_ff <= 2'h0;
            sub_ff <= 8'h00;
            irq_ff <= 1'b0;
            resp_ff <= AUTH_OK;
            exception_o <= 1'b0;
            auth_req_o <= 1'b0;
            scan_probe_o <= 1'b0;
            listen_tech_o <= 4'h0;
            auth_key_o <= '0;
            auth_key_b_o <= 1'b0;
            auth_block_o <= 8'h00;
            auth_uid_o <= '0;
        end else begin
            auth_req_o <= 1'b0;
            scan_probe_o <= 1'b0;
            div_ff <= (ms_tick || in_normal) ? 32'h0 : div_ff + 32'h1;
            auth_cnt_ff <= (state_ff == ST_AUTH) ? auth_cnt_ff + 32'h1 : 32'h0;
            if (ms_tick) begin
                wake_ff <= (wake_ff == WAKE_MIN) ? interval_ff : wake_ff - 16'h1;
            end
            if (frame_done && in_normal) begin
                irq_ff <= 1'b0;
                exception_o <= bad_cmd;
            end
            if (frame_done && in_normal && is_switch && sw_ok) begin
                if (sb_ok) begin
                    state_ff <= ST_STANDBY;
                    wake_en_ff <= p2[1:0];
                    wake_ff <= sb_wake;
                    interval_ff <= sb_wake;
                end else if (lp_ok) begin
                    state_ff <= ST_SCAN;
                    wake_ff <= lp_wake;
                    interval_ff <= lp_wake;
                end else begin
                    state_ff <= ST_LISTEN;
                    listen_tech_o <= p2[3:0];
                    sub_ff <= p3;
                end
            end else if (frame_done && in_normal && is_auth && au_ok) begin
                state_ff <= ST_AUTH;
                auth_req_o <= 1'b1;
                auth_key_o <= shift_ff[95:48];
                auth_key_b_o <= (key_type == KEY_TYPE_B);
                auth_block_o <= shift_ff[39:32];
                auth_uid_o <= shift_ff[31:0];
            end else if (leave) begin
                state_ff <= ST_NORMAL;
                listen_tech_o <= 4'h0;
                if (state_ff == ST_AUTH) begin
                    resp_ff <= !auth_result_valid_i ? AUTH_TIMEOUT
                        : (auth_denied_i ? AUTH_DENIED : AUTH_OK);
                end
            end else if (state_ff == ST_LISTEN && !rf_field_i
                    && sub_ff == LISTEN_SUB_SLEEP) begin
                state_ff <= ST_LISTEN_SB;
            end else if (state_ff == ST_LISTEN_SB && rf_field_i) begin
                state_ff <= ST_LISTEN;
            end
            if (state_ff == ST_SCAN && expire) begin
                scan_probe_o <= 1'b1;
            end
            // event set wins over the clear by a new frame
            if (leave || (frame_done && in_normal && bad_cmd)) begin
                irq_ff <= 1'b1;
            end
        end
    end

    // ********
    // mode indications
    // ********
    assign link.irq = irq_ff;
    assign standby_o = (state_ff == ST_STANDBY) || (state_ff == ST_LISTEN_SB);
    assign low_power_card_detection_o = (state_ff == ST_SCAN);
    assign listen_active_o = (state_ff == ST_LISTEN);
    assign second_general_timer_busy_o = (state_ff == ST_AUTH);
endmodule

//--- shared/mode_auth_pkg.sv
// constants shared by the command link ends
package mode_auth_pkg;
    // ********
    // command codes and frame lengths
    // ********
    localparam logic [7:0] CMD_SWITCH_MODE = 8'h0B;
    localparam logic [7:0] CMD_CARD_AUTH = 8'h0C;
    localparam logic [3:0] LEN_STANDBY = 4'h5;
    localparam logic [3:0] LEN_SCAN = 4'h4;
    localparam logic [3:0] LEN_LISTEN = 4'h4;
    localparam logic [3:0] LEN_AUTH = 4'hD;
    localparam int FRAME_BYTES = 13;
    localparam int FRAME_BITS = 8 * FRAME_BYTES;
    localparam logic [6:0] BIT_CNT_MAX = 7'h7F;
    // ********
    // mode selector and field layout
    // ********
    localparam logic [7:0] MODE_STANDBY = 8'h00;
    localparam logic [7:0] MODE_SCAN = 8'h01;
    localparam logic [7:0] MODE_LISTEN = 8'h02;
    localparam int WAKE_CNT_BIT = 0;
    localparam int WAKE_RF_BIT = 1;
    localparam logic [7:0] WAKE_RSVD_MASK = 8'hFC;
    localparam logic [7:0] TECH_RSVD_MASK = 8'hF0;
    localparam logic [7:0] LISTEN_SUB_ONCE = 8'h00;
    localparam logic [7:0] LISTEN_SUB_SLEEP = 8'h01;
    localparam logic [7:0] LISTEN_SUB_MAX = 8'h02;
    localparam logic [15:0] WAKE_MIN = 16'h0001;
    localparam logic [15:0] WAKE_MAX = 16'h0A82;
    // ********
    // authentication key types and status
    // ********
    localparam logic [7:0] KEY_TYPE_A = 8'h60;
    localparam logic [7:0] KEY_TYPE_B = 8'h61;
    localparam logic [7:0] AUTH_OK = 8'h00;
    localparam logic [7:0] AUTH_DENIED = 8'h01;
    localparam logic [7:0] AUTH_TIMEOUT = 8'h02;
    // ********
    // timing
    // ********
    localparam int SYS_PERIOD_NS = 100;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / SYS_PERIOD_NS;
    localparam int AUTH_TIMEOUT_MS = 5;
    localparam int AUTH_TIMEOUT_CYCLES = AUTH_TIMEOUT_MS * MS_CYCLES;
    localparam int SCK_HALF_CYCLES = 2;
    localparam int SEL_SETUP_CYCLES = 4;
endpackage

//--- shared/cmd_link_if.sv
// serial command link between host controller and frontend
`timescale 1ns/1ps
interface cmd_link_if;
    logic sck;
    logic nss_n;
    logic mosi;
    logic miso;
    logic irq;
    logic dev_rst;
    modport host (output sck, output nss_n, output mosi, output dev_rst,
        input miso, input irq);
    modport dev (input sck, input nss_n, input mosi, input dev_rst,
        output miso, output irq);
endinterface

//--- rtl/mode_auth_host.sv
// host end: sends command frames and reads the status byte
`timescale 1ns/1ps
module mode_auth_host #(
    parameter int HALF = mode_auth_pkg::SCK_HALF_CYCLES,
    parameter int SETUP = mode_auth_pkg::SEL_SETUP_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    cmd_link_if.host link,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic [3:0] req_len_i,
    input wire logic [127:0] req_data_i,
    input wire logic force_reset_i,
    output logic done_o,
    output logic [7:0] rsp_byte_o,
    output logic irq_o
);
    import mode_auth_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_SEL, H_HIGH, H_LOW, H_END, H_GAP} host_state_t;

    host_state_t state_ff;
    logic [127:0] data_ff;
    logic [6:0] bit_ff, last_ff;
    logic [7:0] wait_ff;
    logic [7:0] rx_ff;
    logic sck_ff, nss_ff, mosi_ff, rst_out_ff;
    logic miso_s1_ff, miso_s2_ff, irq_s1_ff, irq_s2_ff;
    logic [6:0] nxt_bit;
    logic wait_done;

    // ********
    // pin synchronisers
    // ********
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            miso_s1_ff <= 1'b0;
            miso_s2_ff <= 1'b0;
            irq_s1_ff <= 1'b0;
            irq_s2_ff <= 1'b0;
        end else begin
            miso_s1_ff <= link.miso;
            miso_s2_ff <= miso_s1_ff;
            irq_s1_ff <= link.irq;
            irq_s2_ff <= irq_s1_ff;
        end
    end

    assign nxt_bit = bit_ff + 7'h01;
    assign wait_done = (wait_ff == 8'h00);

    // ********
    // frame sequencer, msb of byte 0 first
    // ********
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_ff <= H_IDLE;
            data_ff <= '0;
            bit_ff <= 7'h00;
            last_ff <= 7'h00;
            wait_ff <= 8'h00;
            rx_ff <= 8'h00;
            sck_ff <= 1'b0;
            nss_ff <= 1'b1;
            mosi_ff <= 1'b0;
            rst_out_ff <= 1'b0;
            done_o <= 1'b0;
            rsp_byte_o <= 8'h00;
        end else begin
            done_o <= 1'b0;
            rst_out_ff <= force_reset_i;
            wait_ff <= wait_done ? 8'h00 : wait_ff - 8'h01;
            case (state_ff)
                H_IDLE: begin
                    if (req_valid_i && req_len_i != 4'h0) begin
                        data_ff <= req_data_i;
                        last_ff <= {req_len_i, 3'h0} - 7'h01;
                        bit_ff <= 7'h00;
                        nss_ff <= 1'b0;
                        mosi_ff <= req_data_i[7];
                        wait_ff <= 8'(SETUP - 1);
                        state_ff <= H_SEL;
                    end
                end
                H_SEL, H_LOW: begin
                    if (wait_done) begin
                        sck_ff <= 1'b1;
                        rx_ff <= {rx_ff[6:0], miso_s2_ff};
                        wait_ff <= 8'(HALF - 1);
                        state_ff <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (wait_done) begin
                        sck_ff <= 1'b0;
                        wait_ff <= 8'(HALF - 1);
                        if (bit_ff == last_ff) begin
                            state_ff <= H_END;
                        end else begin
                            bit_ff <= nxt_bit;
                            mosi_ff <= data_ff[{nxt_bit[6:3], ~nxt_bit[2:0]}];
                            state_ff <= H_LOW;
                        end
                    end
                end
                H_END: begin
                    if (wait_done) begin
                        nss_ff <= 1'b1;
                        done_o <= 1'b1;
                        rsp_byte_o <= rx_ff;
                        wait_ff <= 8'(SETUP - 1);
                        state_ff <= H_GAP;
                    end
                end
                H_GAP: begin
                    if (wait_done) begin
                        state_ff <= H_IDLE;
                    end
                end
                default: state_ff <= H_IDLE;
            endcase
        end
    end

    // ********
    // link pins
    // ********
    assign req_ready_o = (state_ff == H_IDLE);
    assign link.sck = sck_ff;
    assign link.nss_n = nss_ff;
    assign link.mosi = mosi_ff;
    assign link.dev_rst = rst_out_ff;
    assign irq_o = irq_s2_ff;
endmodule

//--- dv/mode_auth_chk.sv
// assertions on the wires of the command link
`timescale 1ns/1ps
module mode_auth_chk (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic sck,
    input wire logic nss_n,
    input wire logic mosi,
    input wire logic irq,
    input wire logic dev_rst
);
    logic sck_d_ff;
    logic [7:0] bit_cnt_ff;
    logic [7:0] nxt_bit_cnt;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    // ************************************
    // link clock edges counted per frame
    // ************************************
    assign nxt_bit_cnt = nss_n ? 8'h00 : bit_cnt_ff + {7'h00, sck & ~sck_d_ff};
    always_ff @(posedge sys_clk_i) begin
        sck_d_ff <= sck;
        bit_cnt_ff <= nxt_bit_cnt;
    end
    // framing of the serial wire
    sck_idle_a: assert property (nss_n |-> !sck)
        else $error("link clock active outside frame");
    sel_setup_a: assert property ($fell(nss_n) |-> !sck ##1 !sck ##[1:6] sck)
        else $error("frame select not followed by clocking");
    sck_high_a: assert property ($rose(sck) |=> sck ##1 !sck)
        else $error("link clock high phase wrong length");
    mosi_hold_a: assert property (sck |-> $stable(mosi))
        else $error("host data moved while link clock high");
    frame_bytes_a: assert property ($rose(nss_n) |->
        bit_cnt_ff != 8'h00 && bit_cnt_ff[2:0] == 3'h0)
        else $error("frame not a whole number of bytes");
    // interrupt request against frames and reset
    irq_rise_a: assert property ($rose(irq) |-> nss_n && $past(nss_n, 2))
        else $error("interrupt raised inside a frame");
    irq_clear_a: assert property ($fell(irq) |-> nss_n)
        else $error("interrupt cleared inside a frame");
    irq_rst_a: assert property (dev_rst [*4] |=> !irq)
        else $error("interrupt held through device reset");
    cover property ($rose(irq));
    cover property ($rose(nss_n) && bit_cnt_ff == 8'h68);
    cover property (dev_rst [*4]);
endmodule

//--- dv/tb_mode_switch_auth_commands.sv
// self-checking bench joining the host end and the device end
`timescale 1ns/1ps
module tb_mode_switch_auth_commands;
    import mode_auth_pkg::*;
    localparam int MS = 10;
    localparam int TMO = 40;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req_valid = 1'b0;
    logic force_reset = 1'b0;
    logic rf_field = 1'b0;
    logic card_present = 1'b0;
    logic listen_done = 1'b0;
    logic res_valid = 1'b0;
    logic denied = 1'b0;
    logic [3:0] req_len = 4'h0;
    logic [127:0] req_data = '0;
    logic req_ready, done, irq_h, standby, detect, probe, listen_act, auth_req;
    logic key_b, tmr_busy, exc;
    logic [7:0] rsp, blk, blk_e;
    logic [3:0] tech;
    logic [47:0] key_o, key;
    logic [31:0] uid_o, uid;
    logic [31:0] rnd = 32'h0000784D;
    byte unsigned q[$];
    int c;
    int n_mismatch = 0;
    int compares = 0;
    cmd_link_if cmd_link_if_inst ();
    mode_auth_host mode_auth_host_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .link(cmd_link_if_inst), .req_valid_i(req_valid), .req_ready_o(req_ready),
        .req_len_i(req_len), .req_data_i(req_data), .force_reset_i(force_reset),
        .done_o(done), .rsp_byte_o(rsp), .irq_o(irq_h));
    mode_auth_device #(.CYC_PER_MS(MS), .AUTH_TMO_CYC(TMO)) mode_auth_device_inst (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(cmd_link_if_inst),
        .rf_field_i(rf_field), .card_present_i(card_present), .listen_done_i(listen_done),
        .auth_result_valid_i(res_valid), .auth_denied_i(denied), .standby_o(standby),
        .low_power_card_detection_o(detect), .scan_probe_o(probe),
        .listen_active_o(listen_act), .listen_tech_o(tech), .auth_req_o(auth_req),
        .auth_key_o(key_o), .auth_key_b_o(key_b), .auth_block_o(blk), .auth_uid_o(uid_o),
        .second_general_timer_busy_o(tmr_busy), .exception_o(exc));
    mode_auth_chk mode_auth_chk_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .sck(cmd_link_if_inst.sck), .nss_n(cmd_link_if_inst.nss_n),
        .mosi(cmd_link_if_inst.mosi), .irq(cmd_link_if_inst.irq),
        .dev_rst(cmd_link_if_inst.dev_rst));
    always #50 sys_clk_i = ~sys_clk_i;
    // ************************************
    // helpers and reference model
    // ************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // expected rejection of the frame held in q
    function automatic logic exc_exp();
        int n = q.size();
        int w = q[n - 1] * 256 + q[n - 2];
        if (q[0] == CMD_CARD_AUTH)
            return n != FRAME_BYTES || (q[7] != KEY_TYPE_A && q[7] != KEY_TYPE_B);
        case (q[1])
            MODE_STANDBY: return n != LEN_STANDBY || (q[2] & WAKE_RSVD_MASK) != 0
                || (q[2][WAKE_CNT_BIT] && (w < WAKE_MIN || w > WAKE_MAX));
            MODE_SCAN: return n != LEN_SCAN || w < WAKE_MIN || w > WAKE_MAX;
            MODE_LISTEN: return n != LEN_LISTEN || (q[2] & TECH_RSVD_MASK) != 0
                || q[3] > LISTEN_SUB_MAX;
            default: return 1'b1;
        endcase
    endfunction
    function automatic logic sig(input int s);
        case (s)
            0: return done;
            1: return cmd_link_if_inst.irq;
            2: return auth_req;
            3: return probe;
            default: return 1'b0;
        endcase
    endfunction
    task automatic wt(input int s, input int n, output int k);
        for (k = 0; k < n && sig(s) !== 1'b1; k++) @(negedge sys_clk_i);
    endtask
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one frame from q, held until the host takes it
    task automatic send(input int post);
        logic [127:0] d;
        int k;
        d = '0;
        foreach (q[i]) d[8*i +: 8] = q[i];
        @(posedge sys_clk_i);
        req_data <= d;
        req_len <= 4'(q.size());
        req_valid <= 1'b1;
        do @(posedge sys_clk_i); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        wt(0, 800, k);
        chk(done, 1'b1);
        wt(9, post, k);
    endtask
    task automatic wrap_up();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #3000000;
        n_mismatch++;
        wrap_up();
    end
    // ************************************
    // scenarios
    // ************************************
    initial begin
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(negedge sys_clk_i);
        chk({cmd_link_if_inst.irq, standby, detect, listen_act, exc}, 5'h00);
        // rejected frames: flag and interrupt, nothing executed
        for (int e = 0; e < 10; e++) begin
            case (e)
                0: q = '{8'h0B, 8'h03, 8'h01, 8'h01, 8'h00};
                1: q = '{8'h0B, 8'h00, 8'h05, 8'h01, 8'h00};
                2: q = '{8'h0B, 8'h00, 8'h01, 8'h00, 8'h00};
                3: q = '{8'h0B, 8'h00, 8'h01, 8'h83, 8'h0A};
                4: q = '{8'h0B, 8'h01, 8'h00, 8'h00};
                5: q = '{8'h0B, 8'h02, 8'h10, 8'h00};
                6: q = '{8'h0B, 8'h02, 8'h01, 8'h03};
                7: q = '{8'h0C, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h62,
                    8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
                8: q = '{8'h0C, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h60,
                    8'h10, 8'h11, 8'h12, 8'h13};
                default: q = '{8'h0B, 8'h00, 8'h01, 8'h01};
            endcase
            send(9);
            chk({exc, cmd_link_if_inst.irq, irq_h}, {3{exc_exp()}});
            chk({standby, detect, listen_act, tmr_busy}, 4'h0);
        end
        // standby woken by the counter at its lowest value
        q = '{CMD_SWITCH_MODE, MODE_STANDBY, 8'h01, 8'h01, 8'h00};
        send(6);
        chk({standby, exc}, {1'b1, exc_exp()});
        wt(1, 60, c);
        chk(c inside {[2:14]}, 1'b1);
        chk({cmd_link_if_inst.irq, standby}, 2'b10);
        // field wake with an unused zero counter
        q = '{CMD_SWITCH_MODE, MODE_STANDBY, 8'h02, 8'h00, 8'h00};
        send(30);
        chk({standby, exc, cmd_link_if_inst.irq}, 3'b100);
        @(posedge sys_clk_i) rf_field <= 1'b1;
        wt(1, 10, c);
        chk({cmd_link_if_inst.irq, standby}, 2'b10);
        @(posedge sys_clk_i) rf_field <= 1'b0;
        // longest standby: further frames ignored, reset leaves early
        q = '{CMD_SWITCH_MODE, MODE_STANDBY, 8'h01, 8'h82, 8'h0A};
        send(6);
        chk({standby, exc}, 2'b10);
        q = '{CMD_SWITCH_MODE, MODE_SCAN, 8'h02, 8'h00};
        send(6);
        chk({standby, detect}, 2'b10);
        @(posedge sys_clk_i) force_reset <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        force_reset <= 1'b0;
        wt(9, 10, c);
        chk({standby, cmd_link_if_inst.irq}, 2'b00);
        // detection interval of two milliseconds
        q = '{CMD_SWITCH_MODE, MODE_SCAN, 8'h02, 8'h00};
        send(6);
        chk(detect, 1'b1);
        wt(3, 40, c);
        @(negedge sys_clk_i);
        wt(3, 40, c);
        chk(c, 2 * MS - 1);
        @(posedge sys_clk_i) card_present <= 1'b1;
        wt(1, 40, c);
        chk({cmd_link_if_inst.irq, detect}, 2'b10);
        @(posedge sys_clk_i) card_present <= 1'b0;
        // listen sub-modes with a random technology mask
        for (int s = 0; s < 3; s++) begin
            rnd = xs(rnd);
            @(posedge sys_clk_i) rf_field <= 1'b1;
            q = '{CMD_SWITCH_MODE, MODE_LISTEN, rnd[7:0] & 8'h0F, 8'(s)};
            send(6);
            chk({listen_act, tech}, {1'b1, rnd[3:0]});
            @(posedge sys_clk_i) rf_field <= 1'b0;
            wt(1, 8, c);
            chk({cmd_link_if_inst.irq, standby}, s == 0 ? 2'b10 : {1'b0, s == 1});
            if (s > 0) begin
                @(posedge sys_clk_i) rf_field <= 1'b1;
                wt(9, 4, c);
                chk(standby, 1'b0);
                @(posedge sys_clk_i) listen_done <= 1'b1;
                @(posedge sys_clk_i) listen_done <= 1'b0;
                wt(1, 8, c);
                chk(cmd_link_if_inst.irq, 1'b1);
            end
        end
        // authentication: granted, denied, no answer
        for (int t = 0; t < 3; t++) begin
            rnd = xs(rnd);
            key = {rnd, rnd[15:0] ^ 16'hA5C3};
            rnd = xs(rnd);
            uid = rnd;
            blk_e = t == 1 ? 8'hFF : 8'h00;
            q = '{CMD_CARD_AUTH};
            for (int k = 5; k >= 0; k--) q.push_back(key[8*k +: 8]);
            q.push_back(t == 1 ? KEY_TYPE_B : KEY_TYPE_A);
            q.push_back(blk_e);
            for (int k = 3; k >= 0; k--) q.push_back(uid[8*k +: 8]);
            send(0);
            wt(2, 10, c);
            chk({auth_req, key_b, blk, exc}, {1'b1, t == 1, blk_e, exc_exp()});
            chk({key_o, uid_o}, {key, uid});
            chk(tmr_busy, 1'b1);
            if (t < 2) begin
                @(posedge sys_clk_i) res_valid <= 1'b1;
                denied <= t == 1;
                @(posedge sys_clk_i) res_valid <= 1'b0;
            end
            wt(1, TMO + 20, c);
            chk(t < 2 || c > TMO - 8, 1'b1);
            chk({cmd_link_if_inst.irq, tmr_busy}, 2'b10);
            q = '{8'h00};
            send(6);
            chk(rsp, t == 0 ? AUTH_OK : t == 1 ? AUTH_DENIED : AUTH_TIMEOUT);
        end
        wrap_up();
    end
endmodule
